// ==== src/ptg_rate_mode_cfg.sv ====
// Purpose: APB register slice for rate, mode and stop interrupts of four engines
// Assumes: Loop logic outside pulses loop_done when a countdown reaches zero
// Notes: Zero-wait APB slave; read data is captured in the setup cycle
`timescale 1ns/1ns
module ptg_rate_mode_cfg (
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ptg_pkg::PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Loop countdown of each engine reached zero
	input wire logic [3:0] loop_done,
	// Per-engine controls towards the pattern logic
	output logic [3:0] engine_enable,
	output logic [3:0] engine_square_mode,
	output logic [3:0][5:0] engine_pattern_len,
	output logic [3:0] engine_step,
	output logic [3:0] engine_output,
	// Level interrupt
	output logic irq
);
	// Alias for the engine count
	localparam int NE = ptg_pkg::NUM_ENGINES;

	// All state of the register slice
	typedef struct packed {
		logic [3:0] irq_en; // Interrupt enable per engine
		logic [3:0] stop_flags; // Sticky stop flags
		logic [3:0][31:0] rate_mode; // Rate and mode per engine
		logic [3:0] enable; // Engine runs
		logic [3:0] square; // Engine in square wave mode
		logic [3:0][5:0] plen; // Pattern length per engine
		logic [31:0] prdata; // Read data for the access phase
		logic slverr; // Error answer for the access phase
		logic irq; // Interrupt line
	} ptg_regs_t;

	ptg_regs_t st_r;
	ptg_regs_t st_nxt;

	// Divider outputs per engine
	logic [3:0] div_step;
	logic [3:0] div_sq;

	// Bus phase decode
	logic setup_ph;
	logic access_ph;
	logic wr_take;
	logic [2:0] sel;

	// Map a byte address to a register select; unaligned or unknown is none
	function automatic logic [2:0] addr_sel(input logic [ptg_pkg::PADDR_W-1:0] a);
		logic [2:0] s;
		logic [ptg_pkg::PADDR_W-1:0] ra;
		s = ptg_pkg::SEL_NONE;
		ra = '0;
		if (a == ptg_pkg::ADDR_STOP_FLAGS) begin
			s = ptg_pkg::SEL_FLAGS;
		end else if (a == ptg_pkg::ADDR_IRQ_EN) begin
			s = ptg_pkg::SEL_IRQ_EN;
		end
		// One aligned word per engine, spaced by the stride
		for (int i = 0; i < NE; i++) begin
			ra = ptg_pkg::ADDR_RATE_BASE + 12'(i) * ptg_pkg::RATE_STRIDE;
			if (a == ra) begin
				s = ptg_pkg::SEL_RATE | 3'(i);
			end
		end
		return s;
	endfunction

	// Merge write data into a word under the byte strobes
	function automatic logic [31:0] strb_merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0] be
	);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Pattern length that a mode value selects
	function automatic logic [5:0] mode_len(input logic [4:0] m);
		logic [5:0] l;
		l = {1'b0, m};
		if (m == ptg_pkg::MODE_FULL_TRAIN) begin
			l = ptg_pkg::LEN_FULL;
		end else if (m == ptg_pkg::MODE_SQUARE) begin
			l = ptg_pkg::LEN_NONE;
		end
		return l;
	endfunction

	// Phase decode; the slave never waits, so pready follows the access phase
	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign sel = addr_sel(paddr);
	assign wr_take = access_ph & pwrite;

	// Next state of the whole slice
	always_comb begin
		logic [31:0] rd;
		logic [3:0] w1c;
		rd = '0;
		w1c = '0;
		st_nxt = st_r;

		// Read data is sampled in setup so the access phase answers from a flop
		if (setup_ph) begin
			unique case (sel)
				ptg_pkg::SEL_FLAGS: begin
					rd[ptg_pkg::ENG_MSB:ptg_pkg::ENG_LSB] = st_r.stop_flags;
				end
				ptg_pkg::SEL_IRQ_EN: begin
					rd[ptg_pkg::ENG_MSB:ptg_pkg::ENG_LSB] = st_r.irq_en;
				end
				ptg_pkg::SEL_RATE,
				ptg_pkg::SEL_RATE | 3'h1,
				ptg_pkg::SEL_RATE | 3'h2,
				ptg_pkg::SEL_RATE | 3'h3: begin
					rd = st_r.rate_mode[sel[1:0]];
				end
				default: begin
					// Unmapped address reads zero with an error
					rd = '0;
				end
			endcase
			st_nxt.prdata = rd;
			st_nxt.slverr = (sel == ptg_pkg::SEL_NONE);
		end

		// Writes take effect at the access edge only
		if (wr_take) begin
			unique case (sel)
				ptg_pkg::SEL_FLAGS: begin
					// Write one to clear, low byte lane only
					if (pstrb[0]) begin
						w1c = pwdata[ptg_pkg::ENG_MSB:ptg_pkg::ENG_LSB];
					end
				end
				ptg_pkg::SEL_IRQ_EN: begin
					// Upper bits are reserved and stay zero
					if (pstrb[0]) begin
						st_nxt.irq_en = pwdata[ptg_pkg::ENG_MSB:ptg_pkg::ENG_LSB];
					end
				end
				ptg_pkg::SEL_RATE,
				ptg_pkg::SEL_RATE | 3'h1,
				ptg_pkg::SEL_RATE | 3'h2,
				ptg_pkg::SEL_RATE | 3'h3: begin
					// Every mode value is legal, so the word is stored as written
					st_nxt.rate_mode[sel[1:0]] =
						strb_merge(st_r.rate_mode[sel[1:0]], pwdata, pstrb);
				end
				default: begin
					// Unmapped write is dropped
					w1c = '0;
				end
			endcase
		end

		// A countdown ending in the clearing cycle still sets its flag
		st_nxt.stop_flags = (st_r.stop_flags & ~w1c) | loop_done;

		// Decoded controls are registered on the same edge as the stored words
		for (int e = 0; e < NE; e++) begin
			st_nxt.enable[e] =
				(st_nxt.rate_mode[e][ptg_pkg::RATE_MSB:ptg_pkg::RATE_LSB] != '0);
			st_nxt.square[e] =
				(st_nxt.rate_mode[e][ptg_pkg::MODE_MSB:ptg_pkg::MODE_LSB]
				== ptg_pkg::MODE_SQUARE);
			st_nxt.plen[e] =
				mode_len(st_nxt.rate_mode[e][ptg_pkg::MODE_MSB:ptg_pkg::MODE_LSB]);
		end

		// Interrupt tracks the flags and enables that the same edge stores
		st_nxt.irq = |(st_nxt.stop_flags & st_nxt.irq_en);
	end

	// State register; every engine starts in square wave mode and stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.irq_en <= ptg_pkg::IRQ_EN_RESET;
			st_r.stop_flags <= ptg_pkg::STOP_FLAGS_RESET;
			for (int e = 0; e < NE; e++) begin
				st_r.rate_mode[e] <= {ptg_pkg::MODE_RESET, ptg_pkg::RATE_RESET};
				st_r.plen[e] <= ptg_pkg::LEN_NONE;
			end
			st_r.enable <= 4'h0;
			st_r.square <= 4'hf;
			st_r.prdata <= 32'h00000000;
			st_r.slverr <= 1'b0;
			st_r.irq <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// One divider per engine, fed straight from the stored rate field
	for (genvar g = 0; g < NE; g++) begin : g_div
		ptg_rate_div #(
			.RATE_W(ptg_pkg::RATE_W)
		) u_div (
			.pclk(pclk),
			.presetn(presetn),
			.rate(st_r.rate_mode[g][ptg_pkg::RATE_MSB:ptg_pkg::RATE_LSB]),
			.step(div_step[g]),
			.square_out(div_sq[g])
		);
	end

	// Square wave only drives the output in mode one; others leave it low
	assign engine_output = div_sq & st_r.square;
	assign engine_step = div_step;

	// Register-backed outputs
	assign engine_enable = st_r.enable;
	assign engine_square_mode = st_r.square;
	assign engine_pattern_len = st_r.plen;
	assign irq = st_r.irq;

	// APB answer; zero wait states, so ready is combinational on the phase
	assign pready = access_ph;
	assign prdata = st_r.prdata;
	assign pslverr = st_r.slverr & access_ph;
endmodule

// ==== src/ptg_pkg.sv ====
// Purpose: Shared constants for the pulse train rate and mode slice
// Assumes: Four engines, one peripheral clock, 32-bit APB data path
// Notes: Offsets are byte addresses on the APB side
package ptg_pkg;
	// Engine count and bus widths
	localparam int NUM_ENGINES = 4;
	localparam int PADDR_W = 12;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [11:0] ADDR_STOP_FLAGS = 12'h018;
	localparam logic [11:0] ADDR_IRQ_EN = 12'h01c;
	localparam logic [11:0] ADDR_RATE_BASE = 12'h020;
	localparam logic [11:0] RATE_STRIDE = 12'h010;

	// Field layout of the rate and mode register
	localparam int MODE_MSB = 31;
	localparam int MODE_LSB = 27;
	localparam int MODE_W = 5;
	localparam int RATE_MSB = 26;
	localparam int RATE_LSB = 0;
	localparam int RATE_W = 27;

	// Field layout of the enable and flag registers
	localparam int ENG_MSB = 3;
	localparam int ENG_LSB = 0;

	// Reset values
	localparam logic [4:0] MODE_RESET = 5'h01;
	localparam logic [26:0] RATE_RESET = 27'h0000000;
	localparam logic [3:0] IRQ_EN_RESET = 4'h0;
	localparam logic [3:0] STOP_FLAGS_RESET = 4'h0;

	// Mode encodings and pattern lengths
	localparam logic [4:0] MODE_FULL_TRAIN = 5'h00;
	localparam logic [4:0] MODE_SQUARE = 5'h01;
	localparam int LEN_W = 6;
	localparam logic [5:0] LEN_FULL = 6'h20;
	localparam logic [5:0] LEN_NONE = 6'h00;

	// Address decode results; bit 2 marks a rate register, low bits the engine
	localparam logic [2:0] SEL_NONE = 3'h0;
	localparam logic [2:0] SEL_FLAGS = 3'h1;
	localparam logic [2:0] SEL_IRQ_EN = 3'h2;
	localparam logic [2:0] SEL_RATE = 3'h4;
endpackage

// ==== src/ptg_rate_div.sv ====
// Purpose: Divide the engine clock by the programmed rate for one engine
// Assumes: The engine clock is pclk itself
// Notes: A rate of zero holds the counter and the output low
`timescale 1ns/1ns
module ptg_rate_div #(
	parameter int RATE_W = ptg_pkg::RATE_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [RATE_W-1:0] rate,
	output logic step,
	output logic square_out
);
	// All state of the divider
	typedef struct packed {
		logic [RATE_W-1:0] cnt; // Cycles since the last step
		logic step; // One-cycle strobe each rate cycles
		logic sq; // Toggles on each step
	} ptg_div_t;

	ptg_div_t st_r;
	ptg_div_t st_nxt;

	// Next state; compare with >= so a rate shrunk mid-count still wraps
	always_comb begin
		st_nxt = st_r;
		st_nxt.step = 1'b0;
		if (rate == '0) begin
			// Engine disabled: output halted
			st_nxt.cnt = '0;
			st_nxt.sq = 1'b0;
		end else if (st_r.cnt >= rate - 1'b1) begin
			// One state change per rate cycles
			st_nxt.cnt = '0;
			st_nxt.step = 1'b1;
			st_nxt.sq = ~st_r.sq;
		end else begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign step = st_r.step;
	assign square_out = st_r.sq;
endmodule

// ==== verification/ptg_rate_mode_cfg_chk.sv ====
// Purpose: Port checker for the rate and mode register slice
// Assumes: Engine 0 writes in checks use all byte lanes
// Notes: Decode is checked in depth on engine 0 only
`timescale 1ns/1ns
module ptg_rate_mode_cfg_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] loop_done,
	input wire logic [3:0] engine_enable,
	input wire logic [3:0] engine_square_mode,
	input wire logic [3:0][5:0] engine_pattern_len,
	input wire logic [3:0] engine_step,
	input wire logic [3:0] engine_output,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Write access phase, and one aimed at engine 0 with every lane on
	wire logic wr = psel && penable && pwrite;
	wire logic w0 = wr && paddr == ptg_pkg::ADDR_RATE_BASE && pstrb == 4'hf;
	wire logic [4:0] md = pwdata[31:27];
	wire logic [26:0] rt = pwdata[26:0];
	a_pready_zero_wait: assert property (psel && penable |-> pready)
		else $error("pready missing in access phase");
	a_err_read_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("error read returned data");
	a_rate_en: assert property (w0 |=> engine_enable[0] == ($past(rt) != 27'h0))
		else $error("enable does not follow rate");
	a_mode_sq: assert property (w0 |=> engine_square_mode[0] == ($past(md) == 5'h01))
		else $error("square decode wrong");
	a_full_len: assert property (w0 && md == 5'h00 |=> engine_pattern_len[0] == 6'h20)
		else $error("mode zero length wrong");
	a_part_len: assert property (w0 && md > 5'h01
		|=> engine_pattern_len[0] == {1'b0, $past(md)}) else $error("length wrong");
	a_out_sq: assert property ((engine_output & ~engine_square_mode) == 4'h0)
		else $error("output outside square mode");
	a_halt_out: assert property (!engine_enable[0] [*2] |-> !engine_output[0] && !engine_step[0])
		else $error("halted engine moves");
	a_irq_off: assert property (wr && paddr == ptg_pkg::ADDR_IRQ_EN && pwdata[3:0] == 4'h0
		&& pstrb[0] |=> !irq) else $error("irq with all masked");
	a_irq_cause: assert property ($rose(irq) |-> $past(loop_done) != 4'h0 || $past(wr))
		else $error("irq without cause");
	// Main scenarios reached
	c_full: cover property (w0 && md == 5'h00);
	c_irq: cover property ($rose(irq));
	c_err: cover property (psel && penable && pslverr);
endmodule
bind ptg_rate_mode_cfg ptg_rate_mode_cfg_chk u_chk (.*);

// ==== verification/ptg_rate_mode_cfg_tb.sv ====
// Purpose: Self-checking bench for the rate and mode register slice
// Assumes: Zero-wait APB slave; all byte lanes written except in the byte lane test
// Notes: Flags and enables are modelled as integers
`timescale 1ns/1ns
module ptg_rate_mode_cfg_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pready, pslverr, irq, err;
	logic [11:0] paddr = 12'h0, a;
	logic [31:0] pwdata = 32'h0, prdata, rd, w;
	logic [3:0] loop_done = 4'h0, pstrb = 4'hf, en_o, sq_o, st_o, out_o;
	logic [3:0][5:0] len_o;
	int n_errors = 0, samples_checked = 0, seed = 81, flags = 0, ien = 0, m, r, st, tg;
	// 100 MHz clock
	always #5 pclk = ~pclk;
	ptg_rate_mode_cfg DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .loop_done(loop_done), .engine_enable(en_o),
		.engine_square_mode(sq_o), .engine_pattern_len(len_o), .engine_step(st_o),
		.engine_output(out_o), .irq(irq));
	task stop_test;
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x) begin
			n_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		end
	endtask
	// One transfer; the request stands until pready is seen high
	task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		if (i >= 16) begin
			chk(0, 1);
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask
	// One-cycle countdown-done pulse
	task pulse(input logic [3:0] d);
		@(posedge pclk);
		loop_done <= d;
		@(posedge pclk);
		loop_done <= 4'h0;
		flags |= d;
		@(negedge pclk);
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// Refused places first, so the reset reads prove nothing was stored
		apb(1'b1, 12'h021, 32'hffffffff);
		chk(err, 1);
		apb(1'b0, 12'hffc, 32'h0);
		chk(err, 1);
		chk(rd, 32'h0);
		apb(1'b0, ptg_pkg::ADDR_IRQ_EN, 32'h0);
		chk(rd, 0);
		for (m = 0; m < 4; m++) begin
			apb(1'b0, ptg_pkg::ADDR_RATE_BASE + ptg_pkg::RATE_STRIDE * 12'(m), 32'h0);
			chk(rd, 32'h08000000);
		end
		$display("reset test done");
		// Every mode code once, engines in turn, one rate of zero
		for (m = 0; m < 32; m++) begin
			r = (m == 8) ? 0 : $random(seed) & 32'h7ffffff;
			w = {m[4:0], r[26:0]};
			a = ptg_pkg::ADDR_RATE_BASE + ptg_pkg::RATE_STRIDE * 12'(m % 4);
			apb(1'b1, a, w);
			chk({en_o[m%4], sq_o[m%4], len_o[m%4]}, {r != 0, m == 1,
				(m == 0) ? 6'h20 : (m == 1) ? 6'h0 : 6'(m)});
			apb(1'b0, a, 32'h0);
			chk(rd, w);
		end
		// Byte lanes: only the two low lanes of engine 1 may change
		apb(1'b1, ptg_pkg::ADDR_RATE_BASE + ptg_pkg::RATE_STRIDE, 32'h0);
		@(posedge pclk);
		pstrb <= 4'h3;
		apb(1'b1, ptg_pkg::ADDR_RATE_BASE + ptg_pkg::RATE_STRIDE, 32'hffffffff);
		@(posedge pclk);
		pstrb <= 4'hf;
		chk(en_o[1], 1);
		apb(1'b0, ptg_pkg::ADDR_RATE_BASE + ptg_pkg::RATE_STRIDE, 32'h0);
		chk(rd, 32'h0000ffff);
		$display("mode test done");
		// Square wave at a random rate, then rate zero; the window fits every rate
		r = 1 + (($random(seed) & 32'hff) % 6);
		for (m = 0; m < 2; m++) begin
			apb(1'b1, ptg_pkg::ADDR_RATE_BASE, {5'h01, m ? 27'h0 : 27'(r)});
			repeat (4) @(negedge pclk);
			st = 0;
			tg = 0;
			repeat (60) begin
				w[0] = out_o[0];
				@(negedge pclk);
				st += int'(st_o[0]);
				tg += int'(out_o[0] !== w[0]);
			end
			chk(st, m ? 0 : 60 / r);
			chk(tg, m ? 0 : 60 / r);
		end
		$display("rate test done");
		// Masked flag first, then random set, clear and mask
		ien = 5;
		apb(1'b1, ptg_pkg::ADDR_IRQ_EN, 32'h5);
		pulse(4'h2);
		chk(irq, 0);
		for (m = 0; m < 8; m++) begin
			pulse(4'($random(seed)));
			chk(irq, (flags & ien) != 0);
			w = $random(seed);
			apb(1'b1, ptg_pkg::ADDR_STOP_FLAGS, w);
			flags &= ~int'(w[3:0]);
			apb(1'b1, ptg_pkg::ADDR_IRQ_EN, w >> 4);
			ien = w[7:4];
			apb(1'b0, ptg_pkg::ADDR_STOP_FLAGS, 32'h0);
			chk(rd, flags);
			apb(1'b0, ptg_pkg::ADDR_IRQ_EN, 32'h0);
			chk(rd, ien);
			chk(irq, (flags & ien) != 0);
		end
		$display("irq test done");
		stop_test();
	end
endmodule
